//--- logic/sct_chan.sv
// one capture/compare block with its output unit
`timescale 1ns/1ps
`default_nettype none
module sct_chan (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [15:0] count,
  input wire logic cntUpd,
  input wire logic eq0,
  input wire logic evtPin,
  input wire logic auxLvl,
  input wire logic capMode,
  input wire logic [1:0] capEdge,
  input wire logic [1:0] capSel,
  input wire logic swLvl,
  input wire sct_pkg::sct_omode_e outMode,
  input wire logic outBit,
  input wire logic ccrWe,
  input wire logic [15:0] ccrWdata,
  output logic [15:0] ccr,
  output logic hit,
  output logic outPin,
  output logic inLvl
);
  import sct_pkg::*;
  logic [2:0] syn_q;
  logic pinLvl_q;
  logic prev_q;
  logic [15:0] ccr_q;
  logic hit_q;
  logic out_q;
  logic selLvl;
  logic capHit;
  logic eq;

  // three-stage synchroniser; level accepted once stages two and three agree
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syn_q <= 3'h0;
      pinLvl_q <= 1'b0;
    end else if (ce) begin
      syn_q <= {syn_q[1:0], evtPin};
      if (syn_q[1] == syn_q[2]) begin
        pinLvl_q <= syn_q[2];
      end
    end
  end

  // capture source choice and edge detection
  always_comb begin
    case (capSel)
      2'b00: selLvl = pinLvl_q;
      2'b01: selLvl = auxLvl;
      default: selLvl = swLvl;
    endcase
    capHit = capMode & ((capEdge[0] & selLvl & ~prev_q) | (capEdge[1] & ~selLvl & prev_q));
    eq = ~capMode & cntUpd & (count == ccr_q);
  end

  // capture latches the counter and takes priority over a bus write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
      ccr_q <= 16'h0000;
      hit_q <= 1'b0;
    end else if (ce) begin
      prev_q <= selLvl;
      hit_q <= capHit | eq;
      if (capHit) begin
        ccr_q <= count;
      end else if (ccrWe) begin
        ccr_q <= ccrWdata;
      end
    end
  end

  // output unit: first action on own compare, second on block zero compare
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
    end else if (ce) begin
      if (outMode == SCT_OM_BIT) begin
        out_q <= outBit;
      end else if (eq) begin
        case (outMode)
          SCT_OM_SET, SCT_OM_SETRST: out_q <= 1'b1;
          SCT_OM_RST, SCT_OM_RSTSET: out_q <= 1'b0;
          default: out_q <= ~out_q;
        endcase
      end else if (eq0) begin
        case (outMode)
          SCT_OM_TGLRST, SCT_OM_SETRST: out_q <= 1'b0;
          SCT_OM_TGLSET, SCT_OM_RSTSET: out_q <= 1'b1;
          default: out_q <= out_q;
        endcase
      end
    end
  end

  assign ccr = ccr_q;
  assign hit = hit_q;
  assign outPin = out_q;
  assign inLvl = prev_q;
endmodule
`default_nettype wire

//--- logic/sct_pkg.sv
// types shared by the capture/compare timer
package sct_pkg;
  typedef enum logic [1:0] {
    SCT_STOP = 2'b00,
    SCT_UP = 2'b01,
    SCT_CONT = 2'b10,
    SCT_UPDN = 2'b11
  } sct_mode_e;
  typedef enum logic [1:0] {
    SCT_SRC_EXT = 2'b00,
    SCT_SRC_AUX = 2'b01,
    SCT_SRC_MAIN = 2'b10,
    SCT_SRC_MAIN2 = 2'b11
  } sct_src_e;
  typedef enum logic [2:0] {
    SCT_OM_BIT = 3'b000,
    SCT_OM_SET = 3'b001,
    SCT_OM_TGLRST = 3'b010,
    SCT_OM_SETRST = 3'b011,
    SCT_OM_TGL = 3'b100,
    SCT_OM_RST = 3'b101,
    SCT_OM_TGLSET = 3'b110,
    SCT_OM_RSTSET = 3'b111
  } sct_omode_e;
endpackage

//--- logic/sct_regs.svh
// register map, field positions and reset values of the capture/compare timer
`ifndef SCT_REGS_SVH
`define SCT_REGS_SVH
`define SCT_OFS_CTRL 8'h00
`define SCT_OFS_COUNT 8'h04
`define SCT_OFS_IVEC 8'h08
`define SCT_OFS_STAT 8'h0c
`define SCT_OFS_MASK 8'h10
`define SCT_OFS_CH_BASE 8'h20
`define SCT_OFS_CH_LAST 8'h44
// control register fields
`define SCT_CTRL_SRC 1:0
`define SCT_CTRL_DIV 3:2
`define SCT_CTRL_MODE 5:4
`define SCT_CTRL_CLR 6
`define SCT_CTRL_DIR 7
// per-block control fields
`define SCT_CC_CAP 0
`define SCT_CC_EDGE 2:1
`define SCT_CC_SEL 4:3
`define SCT_CC_SWLVL 5
`define SCT_CC_OMODE 8:6
`define SCT_CC_OBIT 9
`define SCT_CC_INLVL 10
`define SCT_CC_OUT 11
// status bit of the counter overflow event
`define SCT_ST_OVF 5
// reset values
`define SCT_RST_CTRL 8'h00
`define SCT_RST_MASK 6'h00
`define SCT_RST_CC 10'h000
// vector word values
`define SCT_VEC_NONE 16'h0000
`define SCT_VEC_BLK1 16'h0002
`define SCT_VEC_BLK2 16'h0004
`define SCT_VEC_BLK3 16'h0006
`define SCT_VEC_BLK4 16'h0008
`define SCT_VEC_OVF 16'h000a
`endif

//--- logic/sct_timer.sv
// sixteen-bit timer with five capture/compare blocks behind an apb slave
`timescale 1ns/1ps
`default_nettype none
`include "sct_regs.svh"
module sct_timer #(
  parameter int NCH = 5
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extClkPin,
  input wire logic auxClkPin,
  input wire logic [NCH-1:0] capPin,
  output logic [NCH-1:0] ccOut,
  output logic irq,
  output logic irqBlk0,
  output logic irqShared
);
  import sct_pkg::*;
  logic [7:0] ctrl_q;
  logic [15:0] cnt_q;
  logic dirDown_q;
  logic cntUpd_q;
  logic [2:0] psc_q;
  logic [2:0] extSyn_q;
  logic [2:0] auxSyn_q;
  logic extLvl_q;
  logic auxLvl_q;
  logic extPrev_q;
  logic auxPrev_q;
  logic [5:0] stat_q;
  logic [5:0] mask_q;
  logic [NCH-1:0] capMode_q;
  logic [NCH-1:0][1:0] capEdge_q;
  logic [NCH-1:0][1:0] capSel_q;
  logic [NCH-1:0] swLvl_q;
  logic [NCH-1:0][2:0] outMode_q;
  logic [NCH-1:0] outBit_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [5:0] vecClr_q;
  logic irq_q;
  logic irqBlk0_q;
  logic irqShared_q;
  logic [NCH-1:0][15:0] ccr;
  logic [NCH-1:0] hit;
  logic [NCH-1:0] inLvl;
  logic srcTick;
  logic cntTick;
  logic ovf;
  logic eq0;
  logic setup;
  logic wrEn;
  logic [15:0] cntNext;
  logic [15:0] vecNow;
  logic [5:0] vecHit;
  logic [5:0] stClr;
  logic [31:0] rdata;
  logic rdErr;
  sct_mode_e mode;

  // true when the address falls on a block's control or value word
  function automatic logic isChan(input logic [7:0] a);
    isChan = (a >= `SCT_OFS_CH_BASE) && (a <= `SCT_OFS_CH_LAST) && (a[1:0] == 2'b00);
  endfunction

  // block index of a block address
  function automatic logic [2:0] chanIdx(input logic [7:0] a);
    logic [7:0] off;
    off = a - `SCT_OFS_CH_BASE;
    chanIdx = off[5:3];
  endfunction

  assign mode = sct_mode_e'(ctrl_q[`SCT_CTRL_MODE]);
  assign setup = psel & ~penable;
  assign wrEn = psel & penable & pready_q & pwrite;

  // three-stage synchronisers for the external and auxiliary clock pins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      extSyn_q <= 3'h0;
      auxSyn_q <= 3'h0;
      extLvl_q <= 1'b0;
      auxLvl_q <= 1'b0;
      extPrev_q <= 1'b0;
      auxPrev_q <= 1'b0;
    end else if (ce) begin
      extSyn_q <= {extSyn_q[1:0], extClkPin};
      auxSyn_q <= {auxSyn_q[1:0], auxClkPin};
      if (extSyn_q[1] == extSyn_q[2]) begin
        extLvl_q <= extSyn_q[2];
      end
      if (auxSyn_q[1] == auxSyn_q[2]) begin
        auxLvl_q <= auxSyn_q[2];
      end
      extPrev_q <= extLvl_q;
      auxPrev_q <= auxLvl_q;
    end
  end

  // source tick: rising edge of a pin clock, or every core cycle for main
  always_comb begin
    case (sct_src_e'(ctrl_q[`SCT_CTRL_SRC]))
      SCT_SRC_EXT: srcTick = extLvl_q & ~extPrev_q;
      SCT_SRC_AUX: srcTick = auxLvl_q & ~auxPrev_q;
      default: srcTick = 1'b1;
    endcase
    cntTick = srcTick && (psc_q == ((3'h1 << ctrl_q[`SCT_CTRL_DIV]) - 3'h1));
  end

  // prescaler counts source ticks; the clear bit restarts it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      psc_q <= 3'h0;
    end else if (ce) begin
      if (wrEn && paddr == `SCT_OFS_CTRL && pwdata[`SCT_CTRL_CLR]) begin
        psc_q <= 3'h0;
      end else if (srcTick) begin
        psc_q <= cntTick ? 3'h0 : psc_q + 3'h1;
      end
    end
  end

  // next counter value and overflow event for the counting modes
  always_comb begin
    cntNext = cnt_q;
    ovf = 1'b0;
    case (mode)
      SCT_UP: begin
        if (cnt_q >= ccr[0]) begin
          cntNext = 16'h0000;
          ovf = 1'b1;
        end else begin
          cntNext = cnt_q + 16'h0001;
        end
      end
      SCT_CONT: begin
        cntNext = cnt_q + 16'h0001;
        ovf = (cnt_q == 16'hffff);
      end
      SCT_UPDN: begin
        if (ccr[0] == 16'h0000) begin
          cntNext = 16'h0000;
        end else if (!dirDown_q) begin
          cntNext = (cnt_q >= ccr[0]) ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
        end else begin
          cntNext = (cnt_q == 16'h0000) ? 16'h0001 : cnt_q - 16'h0001;
          ovf = (cnt_q == 16'h0001);
        end
      end
      default: begin
        cntNext = cnt_q;
      end
    endcase
  end

  // counter: bus write and clear win, otherwise advance on a prescaled tick
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      dirDown_q <= 1'b0;
      cntUpd_q <= 1'b0;
    end else if (ce) begin
      cntUpd_q <= 1'b0;
      if (wrEn && paddr == `SCT_OFS_COUNT) begin
        cnt_q <= pwdata[15:0];
      end else if (wrEn && paddr == `SCT_OFS_CTRL && pwdata[`SCT_CTRL_CLR]) begin
        cnt_q <= 16'h0000;
        dirDown_q <= 1'b0;
      end else if (cntTick && mode != SCT_STOP) begin
        cnt_q <= cntNext;
        cntUpd_q <= 1'b1;
        if (mode == SCT_UPDN) begin
          if (!dirDown_q && cnt_q >= ccr[0]) begin
            dirDown_q <= 1'b1;
          end else if (dirDown_q && cnt_q <= 16'h0001) begin
            dirDown_q <= (cnt_q == 16'h0001);
          end
        end else begin
          dirDown_q <= 1'b0;
        end
      end
    end
  end

  assign eq0 = ~capMode_q[0] & cntUpd_q & (cnt_q == ccr[0]);

  // the five blocks share the one counter
  for (genvar i = 0; i < NCH; i++) begin : gCh
    sct_chan uChan (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .ce(ce),
      .count(cnt_q),
      .cntUpd(cntUpd_q),
      .eq0(eq0),
      .evtPin(capPin[i]),
      .auxLvl(auxLvl_q),
      .capMode(capMode_q[i]),
      .capEdge(capEdge_q[i]),
      .capSel(capSel_q[i]),
      .swLvl(swLvl_q[i]),
      .outMode(sct_omode_e'(outMode_q[i])),
      .outBit(outBit_q[i]),
      .ccrWe(wrEn && isChan(paddr) && paddr[2] && chanIdx(paddr) == 3'(i)),
      .ccrWdata(pwdata[15:0]),
      .ccr(ccr[i]),
      .hit(hit[i]),
      .outPin(ccOut[i]),
      .inLvl(inLvl[i])
    );
  end

  // control and per-block configuration registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `SCT_RST_CTRL;
      mask_q <= `SCT_RST_MASK;
      capMode_q <= '0;
      capEdge_q <= '0;
      capSel_q <= '0;
      swLvl_q <= '0;
      outMode_q <= '0;
      outBit_q <= '0;
    end else if (ce && wrEn) begin
      if (paddr == `SCT_OFS_CTRL) begin
        ctrl_q <= {2'b00, pwdata[5:0]};
      end else if (paddr == `SCT_OFS_MASK) begin
        mask_q <= pwdata[5:0];
      end else if (isChan(paddr) && !paddr[2]) begin
        capMode_q[chanIdx(paddr)] <= pwdata[`SCT_CC_CAP];
        capEdge_q[chanIdx(paddr)] <= pwdata[`SCT_CC_EDGE];
        capSel_q[chanIdx(paddr)] <= pwdata[`SCT_CC_SEL];
        swLvl_q[chanIdx(paddr)] <= pwdata[`SCT_CC_SWLVL];
        outMode_q[chanIdx(paddr)] <= pwdata[`SCT_CC_OMODE];
        outBit_q[chanIdx(paddr)] <= pwdata[`SCT_CC_OBIT];
      end
    end
  end

  // shared-vector priority: block one first, overflow last, zero when idle
  always_comb begin
    vecNow = `SCT_VEC_NONE;
    vecHit = 6'h00;
    if (stat_q[1] & mask_q[1]) begin
      vecNow = `SCT_VEC_BLK1;
      vecHit = 6'h02;
    end else if (stat_q[2] & mask_q[2]) begin
      vecNow = `SCT_VEC_BLK2;
      vecHit = 6'h04;
    end else if (stat_q[3] & mask_q[3]) begin
      vecNow = `SCT_VEC_BLK3;
      vecHit = 6'h08;
    end else if (stat_q[4] & mask_q[4]) begin
      vecNow = `SCT_VEC_BLK4;
      vecHit = 6'h10;
    end else if (stat_q[`SCT_ST_OVF] & mask_q[`SCT_ST_OVF]) begin
      vecNow = `SCT_VEC_OVF;
      vecHit = 6'h20;
    end
  end

  // bits cleared this cycle: write-one to status, or the flag a vector read reported
  assign stClr = (wrEn && paddr == `SCT_OFS_STAT) ? pwdata[5:0] :
    (psel && penable && pready_q && !pwrite && paddr == `SCT_OFS_IVEC) ? vecClr_q : 6'h00;

  // sticky status: events set, write-one and vector read clear, set wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= 6'h00;
    end else if (ce) begin
      stat_q <= (stat_q & ~stClr) | {ovf & cntTick & (mode != SCT_STOP), hit};
    end
  end

  // interrupt outputs: block zero, shared vector and their union
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
      irqBlk0_q <= 1'b0;
      irqShared_q <= 1'b0;
    end else if (ce) begin
      irqBlk0_q <= stat_q[0] & mask_q[0];
      irqShared_q <= |(stat_q[5:1] & mask_q[5:1]);
      irq_q <= |(stat_q & mask_q);
    end
  end

  // read multiplexer
  always_comb begin
    rdata = 32'h0000_0000;
    rdErr = 1'b0;
    if (paddr == `SCT_OFS_CTRL) begin
      rdata = {24'h000000, dirDown_q, 1'b0, ctrl_q[5:0]};
    end else if (paddr == `SCT_OFS_COUNT) begin
      rdata = {16'h0000, cnt_q};
    end else if (paddr == `SCT_OFS_IVEC) begin
      rdata = {16'h0000, vecNow};
    end else if (paddr == `SCT_OFS_STAT) begin
      rdata = {26'h0000000, stat_q};
    end else if (paddr == `SCT_OFS_MASK) begin
      rdata = {26'h0000000, mask_q};
    end else if (isChan(paddr) && paddr[2]) begin
      rdata = {16'h0000, ccr[chanIdx(paddr)]};
    end else if (isChan(paddr)) begin
      rdata = {20'h00000, ccOut[chanIdx(paddr)], inLvl[chanIdx(paddr)],
               outBit_q[chanIdx(paddr)], outMode_q[chanIdx(paddr)],
               swLvl_q[chanIdx(paddr)], capSel_q[chanIdx(paddr)],
               capEdge_q[chanIdx(paddr)], capMode_q[chanIdx(paddr)]};
    end else begin
      rdErr = 1'b1;
    end
  end

  // apb answer: read data sampled in setup, ready raised for one access cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      vecClr_q <= 6'h00;
    end else if (ce) begin
      if (setup) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rdata;
        pready_q <= 1'b1;
        pslverr_q <= rdErr;
        vecClr_q <= vecHit;
      end else begin
        pready_q <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign irqBlk0 = irqBlk0_q;
  assign irqShared = irqShared_q;
endmodule
`default_nettype wire

//--- verification/sct_pins.sv
// far-side pin model: timer clock, crystal clock and capture event pins
`timescale 1ns/1ps
`default_nettype none
module sct_pins #(
  parameter int AUX_HALF = 8
) (
  input wire logic core_clk,
  output logic extClkPin,
  output logic auxClkPin,
  output logic [4:0] capPin,
  input wire logic [4:0] ccOut
);
  int auxCnt = 0;
  initial begin
    extClkPin = 1'b0;
    auxClkPin = 1'b0;
    capPin = 5'h00;
  end
  // crystal clock runs free, a fixed number of core cycles per half period
  always @(posedge core_clk) begin
    auxCnt <= (auxCnt == AUX_HALF - 1) ? 0 : auxCnt + 1;
    if (auxCnt == AUX_HALF - 1)
      auxClkPin <= ~auxClkPin;
  end
  // timer clock pulses, wide enough for the input synchroniser
  task automatic extPulses(input int n);
    repeat (n) begin
      @(posedge core_clk);
      extClkPin <= 1'b1;
      repeat (4) @(posedge core_clk);
      extClkPin <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask
  // drives one capture event pin to a level
  task automatic setCap(input int i, input logic v);
    @(posedge core_clk);
    capPin[i] <= v;
  endtask
endmodule
`default_nettype wire

//--- verification/sct_timer_properties.sv
// port assertions of the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module sct_timer_checker #(
  parameter int NCH = 5
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NCH-1:0] ccOut,
  input wire logic irq,
  input wire logic irqBlk0,
  input wire logic irqShared
);
  logic aligned;
  logic inMap;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // decode of the populated word addresses
  assign aligned = paddr[1:0] == 2'b00;
  assign inMap = paddr <= 8'h10 || (paddr >= 8'h20 && paddr <= 8'h44);
  // a setup cycle taken by the slave
  sequence setupS;
    psel && !penable && ce;
  endsequence
  sequence badSetupS;
    setupS ##0 (aligned && !inMap);
  endsequence
  a_ready_after_setup: assert property (setupS |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready && ce |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_needs_setup: assert property (!psel && ce |=> !pready)
    else $error("pready without a request");
  a_unmapped_error: assert property (badSetupS |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_no_error: assert property (setupS ##0 (aligned && inMap) |=> !pslverr)
    else $error("error on a mapped access");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside the access cycle");
  a_irq_combined: assert property (irq == (irqBlk0 || irqShared))
    else $error("combined interrupt disagrees with vectors");
  a_reset_quiet: assert property ($rose(rst_n) |-> ccOut == '0 && !irq && !pready)
    else $error("outputs active after reset");
  a_ce_freeze: assert property (!ce |=> $stable(ccOut) && $stable(pready) && $stable(irq))
    else $error("state moved while clock enable low");
endmodule
bind sct_timer sct_timer_checker #(.NCH(NCH)) u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .ce(ce), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ccOut(ccOut), .irq(irq), .irqBlk0(irqBlk0),
  .irqShared(irqShared));
`default_nettype wire

//--- verification/test_sct_timer.sv
// self-checking bench of the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module test_sct_timer;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
  } sct_row_s;
  localparam logic WR = 1'b1;
  localparam logic RD = 1'b0;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic extClkPin;
  logic auxClkPin;
  logic [4:0] capPin;
  logic [4:0] ccOut;
  logic irq;
  logic irqBlk0;
  logic irqShared;
  logic [31:0] rd;
  logic [31:0] r0;
  int errors = 0;
  int comparisons = 0;
  // register rows: reset values, access kinds, software capture edges
  sct_row_s rows [40] = '{
    '{RD, 8'h00, 32'h0}, '{RD, 8'h04, 32'h0}, '{RD, 8'h08, 32'h0}, '{RD, 8'h0c, 32'h0},
    '{RD, 8'h10, 32'h0}, '{RD, 8'h20, 32'h0}, '{RD, 8'h24, 32'h0},
    '{WR, 8'h10, 32'h3f}, '{RD, 8'h10, 32'h3f}, '{WR, 8'h44, 32'hffff}, '{RD, 8'h44, 32'hffff},
    '{WR, 8'h08, 32'hffff}, '{RD, 8'h08, 32'h0}, '{WR, 8'h14, 32'h5a5a}, '{RD, 8'h14, 32'h0},
    '{WR, 8'h00, 32'h40}, '{RD, 8'h00, 32'h0}, '{WR, 8'h04, 32'hbeef}, '{RD, 8'h04, 32'hbeef},
    '{WR, 8'h30, 32'h200}, '{RD, 8'h30, 32'ha00},
    '{WR, 8'h04, 32'h222}, '{WR, 8'h28, 32'h13}, '{WR, 8'h28, 32'h33}, '{RD, 8'h2c, 32'h222},
    '{WR, 8'h04, 32'h333}, '{WR, 8'h28, 32'h13}, '{RD, 8'h2c, 32'h222},
    '{WR, 8'h04, 32'h444}, '{WR, 8'h28, 32'h35}, '{RD, 8'h2c, 32'h222},
    '{WR, 8'h04, 32'h555}, '{WR, 8'h28, 32'h15}, '{RD, 8'h2c, 32'h555},
    '{WR, 8'h04, 32'h666}, '{WR, 8'h28, 32'h37}, '{RD, 8'h2c, 32'h666},
    '{WR, 8'h04, 32'h777}, '{WR, 8'h28, 32'h17}, '{RD, 8'h2c, 32'h777}};
  logic [7:0] ctlTab [6] = '{8'h22, 8'h26, 8'h2a, 8'h2f, 8'h21, 8'h25};
  logic [31:0] incTab [6] = '{32'h40, 32'h20, 32'h10, 32'h8, 32'h4, 32'h2};

  // 125 MHz core clock
  always #4 core_clk = ~core_clk;

  sct_timer #(.NCH(5)) dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .extClkPin(extClkPin), .auxClkPin(auxClkPin),
    .capPin(capPin), .ccOut(ccOut), .irq(irq), .irqBlk0(irqBlk0), .irqShared(irqShared));
  sct_pins pins (.core_clk(core_clk), .extClkPin(extClkPin), .auxClkPin(auxClkPin),
    .capPin(capPin), .ccOut(ccOut));

  // counts, verdict and end of run
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // value comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, read data kept in rd
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      errors++;
      test_done();
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(RD, a, 32'h0);
    chk(rd, e);
  endtask
  // counter advance between two reads 64 cycles apart; the clear bit restarts the prescaler
  task automatic advance(input logic [7:0] ctl, input int low, input logic [31:0] e);
    apb(WR, 8'h00, {24'h0, ctl | 8'h40});
    apb(RD, 8'h04, 32'h0);
    r0 = rd;
    repeat (20) @(posedge core_clk);
    ce <= (low == 0);
    repeat (10) @(posedge core_clk);
    ce <= 1'b1;
    repeat (31) @(posedge core_clk);
    apb(RD, 8'h04, 32'h0);
    chk({16'h0, rd[15:0] - r0[15:0]}, e);
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].data);
      if (!rows[i].wr)
        chk(rd, rows[i].data);
    end
    for (int k = 0; k < 6; k++)
      advance(ctlTab[k], 0, incTab[k]);
    advance(8'h22, 1, 32'h36);
    apb(WR, 8'h00, 32'h20);
    apb(WR, 8'h04, 32'h0);
    pins.extPulses(5);
    repeat (8) @(posedge core_clk);
    rdc(8'h04, 32'h5);
    for (int m = 0; m < 2; m++) begin
      apb(WR, 8'h00, 32'h02);
      apb(WR, 8'h04, 32'h0);
      apb(WR, 8'h24, m ? 32'h3 : 32'h9);
      apb(WR, 8'h0c, 32'h3f);
      apb(WR, 8'h00, m ? 32'h32 : 32'h12);
      repeat (40) @(posedge core_clk);
      apb(WR, 8'h00, 32'h02);
      rdc(8'h0c, 32'h2d);
      chk({30'h0, irqBlk0, irqShared}, 32'h3);
      rdc(8'h08, 32'h4);
      rdc(8'h08, 32'h6);
      rdc(8'h08, 32'ha);
      rdc(8'h08, 32'h0);
      apb(WR, 8'h10, 32'h3e);
      repeat (3) @(posedge core_clk);
      chk({29'h0, irq, irqBlk0, irqShared}, 32'h0);
      apb(WR, 8'h0c, 32'h1);
      apb(WR, 8'h10, 32'h3f);
      rdc(8'h0c, 32'h0);
    end
    apb(WR, 8'h34, 32'h2);
    apb(WR, 8'h30, 32'hc0);
    apb(WR, 8'h04, 32'h0);
    apb(WR, 8'h00, 32'h10);
    pins.extPulses(3);
    repeat (4) @(posedge core_clk);
    chk({27'h0, ccOut}, 32'h0);
    pins.extPulses(3);
    repeat (4) @(posedge core_clk);
    chk({27'h0, ccOut}, 32'h4);
    apb(WR, 8'h00, 32'h02);
    apb(WR, 8'h04, 32'habc);
    apb(WR, 8'h38, 32'h3);
    pins.setCap(3, 1'b1);
    repeat (10) @(posedge core_clk);
    rdc(8'h3c, 32'habc);
    apb(WR, 8'h04, 32'hdef);
    apb(WR, 8'h40, 32'hb);
    repeat (40) @(posedge core_clk);
    rdc(8'h44, 32'hdef);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk({27'h0, ccOut}, 32'h0);
    rdc(8'h2c, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
